// file: logic/ipm_pkg.sv
// Register map, field layout and carrier types of the input gain block
package ipm_pkg;
  // Printed offsets are register indices; byte address is four times these
  localparam logic [7:0] IDX_POWER = 8'h02;
  localparam logic [7:0] IDX_BOOST = 8'h15;
  localparam logic [7:0] IDX_GAIN_1L = 8'h18;
  localparam logic [7:0] IDX_GAIN_2L = 8'h19;
  localparam logic [7:0] IDX_GAIN_1R = 8'h1a;
  localparam logic [7:0] IDX_GAIN_2R = 8'h1b;
  localparam logic [7:0] IDX_SELECT = 8'h28;
  localparam logic [7:0] IDX_LMIX_AMP = 8'h29;
  localparam logic [7:0] IDX_RMIX_AMP = 8'h2a;
  localparam logic [7:0] IDX_LMIX_SRC = 8'h2b;
  localparam logic [7:0] IDX_RMIX_SRC = 8'h2c;
  localparam logic [7:0] IDX_TIMEOUT = 8'h30;
  localparam logic [7:0] IDX_STATUS = 8'h31;

  localparam int POS_LMIX_ENA = 9;
  localparam int POS_RMIX_ENA = 8;
  localparam int POS_MIDBUF = 2;
  localparam int POS_BIAS = 0;
  localparam int POS_VU = 8;
  localparam int POS_SILENCE = 7;
  localparam int POS_ZC = 6;
  localparam int POS_LBOOST = 7;
  localparam int POS_RBOOST = 8;
  localparam int POS_SECOND_UNMUTE = 8;
  localparam int POS_SECOND_GAIN = 7;
  localparam int POS_FIRST_UNMUTE = 5;
  localparam int POS_FIRST_GAIN = 4;
  localparam int POS_HI_SRC = 6;
  localparam int POS_TO_ENA = 15;

  localparam logic [4:0] GAIN_RESET = 5'h0b;
  localparam logic [2:0] SRC_MUTE = 3'h0;
  localparam logic [2:0] SRC_TOP = 3'h7;
  localparam logic [3:0] BOOST_DB = 4'hf;
  localparam logic [3:0] PLAIN_TOP_DB = 4'h6;
  localparam logic [14:0] TO_DIV_RESET = 15'h03ff;

  localparam int NUM_AMPS = 4;
  localparam int GAIN_W = 5;

  typedef struct packed {
    logic [4:0] gain_code;
    logic zero_cross_gate;
    logic silence_req;
    logic armed;
    logic pending;
  } ipm_amp_t;

  typedef struct packed {
    logic unmute_first;
    logic gain_first;
    logic unmute_second;
    logic gain_second;
    logic [2:0] bypass_lvl;
    logic [2:0] voice_lvl;
    logic [2:0] record_lvl;
    logic boost;
    logic enable;
  } ipm_mix_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [9:0] adr;
    logic [31:0] dat;
  } ipm_wb_req_t;
endpackage

// file: logic/ipm_amp_gain.sv
// One input amplifier: staged gain code, zero-cross gate and mute latch
`timescale 1ns/1ps
module ipm_amp_gain #(
  parameter int GW = ipm_pkg::GAIN_W
) (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_soft_rst,
  input wire logic [GW-1:0] i_staged_gain,
  input wire logic i_zc_gate,
  input wire logic i_silence_bit,
  input wire logic i_apply,
  input wire logic i_zero_cross,
  input wire logic i_timeout_tick,
  output logic [GW-1:0] o_active_gain,
  output logic o_muted,
  output logic o_pending
);
  typedef struct packed {
    logic [GW-1:0] act;
    logic [GW-1:0] held;
    logic pend;
    logic armed;
    logic muted;
  } ipm_amp_st_t;

  ipm_amp_st_t st_q;
  ipm_amp_st_t st_d;
  logic zc_s1_q;
  logic zc_s2_q;

  // Zero-cross indication comes from the analogue comparator domain
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      zc_s1_q <= 1'b0;
      zc_s2_q <= 1'b0;
    end else begin
      zc_s1_q <= i_zero_cross;
      zc_s2_q <= zc_s1_q;
    end
  end

  always_comb begin
    st_d = st_q;
    if (i_soft_rst) begin
      st_d.act = ipm_pkg::GAIN_RESET;
      st_d.held = ipm_pkg::GAIN_RESET;
      st_d.pend = 1'b0;
      st_d.armed = 1'b0;
      st_d.muted = 1'b0;
    end else begin
      // Mute arms only after the bit has been seen at 0 once
      if (!i_silence_bit) begin
        st_d.armed = 1'b1;
      end
      st_d.muted = i_silence_bit && (st_q.armed || !i_silence_bit);
      if (i_apply) begin
        st_d.held = i_staged_gain;
        if (i_zc_gate) begin
          st_d.pend = 1'b1;
        end else begin
          st_d.act = i_staged_gain;
          st_d.pend = 1'b0;
        end
      end else if (st_q.pend && (zc_s2_q || i_timeout_tick)) begin
        st_d.act = st_q.held;
        st_d.pend = 1'b0;
      end else if (st_q.pend && !i_zc_gate) begin
        st_d.act = st_q.held;
        st_d.pend = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      st_q <= '{act: ipm_pkg::GAIN_RESET, held: ipm_pkg::GAIN_RESET,
                pend: 1'b0, armed: 1'b0, muted: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign o_active_gain = st_q.act;
  assign o_muted = st_q.muted;
  assign o_pending = st_q.pend;
endmodule

// file: logic/ipm_tick_div.sv
// Timeout tick divider: one-cycle enable pulse every divider+1 cycles
`timescale 1ns/1ps
module ipm_tick_div #(
  parameter int DW = 15
) (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_soft_rst,
  input wire logic i_enable,
  input wire logic [DW-1:0] i_divider,
  output logic o_tick
);
  typedef struct packed {
    logic [DW-1:0] cnt;
    logic tick;
  } ipm_div_st_t;

  ipm_div_st_t st_q;
  ipm_div_st_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.tick = 1'b0;
    if (i_soft_rst || !i_enable) begin
      st_d.cnt = '0;
    end else if (st_q.cnt >= i_divider) begin
      st_d.cnt = '0;
      st_d.tick = 1'b1;
    end else begin
      st_d.cnt = st_q.cnt + DW'(1);
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_tick = st_q.tick;
endmodule

// file: logic/ipm_input_ctrl.sv
// Record front end control: amplifier gain, input select and mixer levels
`timescale 1ns/1ps
module ipm_input_ctrl #(
  parameter int NA = ipm_pkg::NUM_AMPS,
  parameter int GW = ipm_pkg::GAIN_W
) (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_soft_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [3:0] i_wb_sel,
  input wire logic [9:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic [NA-1:0] i_zero_cross,
  output logic [7:0] o_pos_pin_select,
  output logic [NA*GW-1:0] o_active_gain,
  output logic [NA-1:0] o_amp_muted,
  output logic o_midrail_buffer_enable,
  output logic o_master_bias_enable,
  output logic o_left_record_mixer_enable,
  output logic o_right_record_mixer_enable,
  output logic [7:0] o_left_mix_levels,
  output logic [7:0] o_right_mix_levels
);
  // Amplifier order: 0 first left, 1 second left, 2 first right, 3 second right
  typedef struct packed {
    logic [15:0] power;
    logic [15:0] boost;
    logic [NA-1:0][15:0] gain;
    logic [15:0] select;
    logic [15:0] lmix_amp;
    logic [15:0] rmix_amp;
    logic [15:0] lmix_src;
    logic [15:0] rmix_src;
    logic [15:0] timeout;
    logic [7:0] lmix_lvl;
    logic [7:0] rmix_lvl;
    logic ack;
    logic [31:0] rdata;
  } ipm_regs_t;

  ipm_regs_t st_q;
  ipm_regs_t st_d;
  ipm_pkg::ipm_wb_req_t req;
  logic [NA-1:0] apply;
  logic [NA-1:0] pending;
  logic tick;
  logic [NA*GW-1:0] gain_act;
  logic access;
  logic wr;
  logic [7:0] idx;

  // Merge a 16-bit register with byte lanes of the write data
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wdat,
                                          input logic [3:0] sel);
    logic [15:0] r;
    r = old;
    if (sel[0]) begin
      r[7:0] = wdat[7:0];
    end
    if (sel[1]) begin
      r[15:8] = wdat[15:8];
    end
    return r;
  endfunction

  // Mixer source level in dB, 0 meaning muted path; offset +13 keeps it unsigned
  function automatic logic [4:0] src_db(input logic [2:0] code,
                                        input logic boost_on);
    logic [4:0] r;
    r = 5'h00;
    if (code == ipm_pkg::SRC_MUTE) begin
      r = 5'h00;
    end else if (code == ipm_pkg::SRC_TOP && boost_on) begin
      r = 5'(ipm_pkg::BOOST_DB) + 5'h0d;
    end else begin
      r = 5'(code) * 5'h03 - 5'h02;
    end
    return r;
  endfunction

  // Amplifiers moved by one pair strobe; the register index picks the pair
  function automatic logic [NA-1:0] pair_mask(input logic [7:0] reg_idx);
    logic [NA-1:0] r;
    for (int a = 0; a < NA; a++) begin
      r[a] = (a % 2) == int'(reg_idx[0]);
    end
    return r;
  endfunction

  // Pack one mixer's source states: same layout for left and right
  function automatic logic [7:0] mix_levels(input logic [15:0] amp_lvl,
                                            input logic [15:0] src_lvl,
                                            input logic boost_on,
                                            input logic enable);
    logic [7:0] r;
    r[7] = amp_lvl[ipm_pkg::POS_FIRST_UNMUTE];
    r[6] = amp_lvl[ipm_pkg::POS_SECOND_UNMUTE];
    r[5] = |src_db(src_lvl[8:6], boost_on);
    r[4] = |src_db(src_lvl[2:0], 1'b0);
    r[3] = |src_db(amp_lvl[2:0], 1'b0);
    r[2] = enable;
    r[1] = amp_lvl[ipm_pkg::POS_FIRST_GAIN];
    r[0] = amp_lvl[ipm_pkg::POS_SECOND_GAIN];
    return r;
  endfunction

  assign req = '{cyc: i_wb_cyc, stb: i_wb_stb, we: i_wb_we, sel: i_wb_sel,
                 adr: i_wb_adr, dat: i_wb_dat};
  assign access = req.cyc && req.stb && !st_q.ack;
  assign wr = access && req.we;
  assign idx = req.adr[9:2];

  always_comb begin
    st_d = st_q;
    st_d.ack = access;
    apply = '0;
    if (i_soft_rst) begin
      st_d.power = '0;
      st_d.boost = '0;
      for (int a = 0; a < NA; a++) begin
        st_d.gain[a] = 16'h0080 | 16'(ipm_pkg::GAIN_RESET);
      end
      st_d.select = '0;
      st_d.lmix_amp = '0;
      st_d.rmix_amp = '0;
      st_d.lmix_src = '0;
      st_d.rmix_src = '0;
      st_d.timeout = 16'(ipm_pkg::TO_DIV_RESET);
    end else if (wr) begin
      unique case (idx)
        ipm_pkg::IDX_POWER: st_d.power = merge16(st_q.power, req.dat, req.sel);
        ipm_pkg::IDX_BOOST: st_d.boost = merge16(st_q.boost, req.dat, req.sel);
        ipm_pkg::IDX_SELECT: begin
          st_d.select = merge16(st_q.select, req.dat, req.sel);
        end
        ipm_pkg::IDX_LMIX_AMP: begin
          st_d.lmix_amp = merge16(st_q.lmix_amp, req.dat, req.sel);
        end
        ipm_pkg::IDX_RMIX_AMP: begin
          st_d.rmix_amp = merge16(st_q.rmix_amp, req.dat, req.sel);
        end
        ipm_pkg::IDX_LMIX_SRC: begin
          st_d.lmix_src = merge16(st_q.lmix_src, req.dat, req.sel);
        end
        ipm_pkg::IDX_RMIX_SRC: begin
          st_d.rmix_src = merge16(st_q.rmix_src, req.dat, req.sel);
        end
        ipm_pkg::IDX_TIMEOUT: begin
          st_d.timeout = merge16(st_q.timeout, req.dat, req.sel);
        end
        ipm_pkg::IDX_GAIN_1L, ipm_pkg::IDX_GAIN_2L,
        ipm_pkg::IDX_GAIN_1R, ipm_pkg::IDX_GAIN_2R: begin
          for (int a = 0; a < NA; a++) begin
            if (idx == ipm_pkg::IDX_GAIN_1L + 8'(a)) begin
              // Strobe bit is never stored; it only fires the pair
              st_d.gain[a] = merge16(st_q.gain[a], req.dat, req.sel)
                             & ~(16'h0001 << ipm_pkg::POS_VU);
            end
          end
          if (req.sel[1] && req.dat[ipm_pkg::POS_VU]) begin
            // Left and right of one pair share a strobe
            apply = pair_mask(idx);
          end
        end
        default: ;
      endcase
    end
    // Apply uses the newly written code when strobe and code share a write
    st_d.rdata = '0;
    if (access && !req.we) begin
      unique case (idx)
        ipm_pkg::IDX_POWER: st_d.rdata = 32'(st_q.power);
        ipm_pkg::IDX_BOOST: st_d.rdata = 32'(st_q.boost);
        ipm_pkg::IDX_GAIN_1L: st_d.rdata = 32'(st_q.gain[0]);
        ipm_pkg::IDX_GAIN_2L: st_d.rdata = 32'(st_q.gain[1]);
        ipm_pkg::IDX_GAIN_1R: st_d.rdata = 32'(st_q.gain[2]);
        ipm_pkg::IDX_GAIN_2R: st_d.rdata = 32'(st_q.gain[3]);
        ipm_pkg::IDX_SELECT: st_d.rdata = 32'(st_q.select);
        ipm_pkg::IDX_LMIX_AMP: st_d.rdata = 32'(st_q.lmix_amp);
        ipm_pkg::IDX_RMIX_AMP: st_d.rdata = 32'(st_q.rmix_amp);
        ipm_pkg::IDX_LMIX_SRC: st_d.rdata = 32'(st_q.lmix_src);
        ipm_pkg::IDX_RMIX_SRC: st_d.rdata = 32'(st_q.rmix_src);
        ipm_pkg::IDX_TIMEOUT: st_d.rdata = 32'(st_q.timeout);
        ipm_pkg::IDX_STATUS: st_d.rdata = {24'h000000, o_amp_muted, pending};
        default: st_d.rdata = '0;
      endcase
    end
    // Registered so the analogue side never sees decode glitches
    st_d.lmix_lvl = mix_levels(st_d.lmix_amp, st_d.lmix_src,
                               st_d.boost[ipm_pkg::POS_LBOOST],
                               st_d.power[ipm_pkg::POS_LMIX_ENA]);
    st_d.rmix_lvl = mix_levels(st_d.rmix_amp, st_d.rmix_src,
                               st_d.boost[ipm_pkg::POS_RBOOST],
                               st_d.power[ipm_pkg::POS_RMIX_ENA]);
  end

  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      st_q <= '0;
      st_q.gain <= {NA{16'h0080 | 16'(ipm_pkg::GAIN_RESET)}};
      st_q.timeout <= 16'(ipm_pkg::TO_DIV_RESET);
    end else begin
      st_q <= st_d;
    end
  end

  ipm_tick_div #(
    .DW(15)
  ) u_tick (
    .i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn),
    .i_soft_rst(i_soft_rst),
    .i_enable(st_q.timeout[ipm_pkg::POS_TO_ENA]),
    .i_divider(st_q.timeout[14:0]),
    .o_tick(tick)
  );

  for (genvar a = 0; a < NA; a++) begin : g_amp
    ipm_amp_gain #(
      .GW(GW)
    ) u_amp (
      .i_clk_sys(i_clk_sys),
      .i_rstn(i_rstn),
      .i_soft_rst(i_soft_rst),
      .i_staged_gain(st_d.gain[a][GW-1:0]),
      // Gate bit written with the strobe governs that same apply
      .i_zc_gate(st_d.gain[a][ipm_pkg::POS_ZC]),
      .i_silence_bit(st_q.gain[a][ipm_pkg::POS_SILENCE]),
      .i_apply(apply[a]),
      .i_zero_cross(i_zero_cross[a]),
      .i_timeout_tick(tick),
      .o_active_gain(gain_act[a*GW +: GW]),
      .o_muted(o_amp_muted[a]),
      .o_pending(pending[a])
    );
  end

  // Pin select order: 7 2L+, 6 2L-, 5 1L+, 4 1L-, 3 2R+, 2 2R-, 1 1R+, 0 1R-
  assign o_pos_pin_select = st_q.select[7:0];
  assign o_active_gain = gain_act;
  assign o_midrail_buffer_enable = st_q.power[ipm_pkg::POS_MIDBUF];
  assign o_master_bias_enable = st_q.power[ipm_pkg::POS_BIAS];
  assign o_left_record_mixer_enable = st_q.power[ipm_pkg::POS_LMIX_ENA];
  assign o_right_record_mixer_enable = st_q.power[ipm_pkg::POS_RMIX_ENA];

  // Five sources per mixer, packed as enables and levels
  assign o_left_mix_levels = st_q.lmix_lvl;
  assign o_right_mix_levels = st_q.rmix_lvl;

  assign o_wb_ack = st_q.ack;
  assign o_wb_dat = st_q.rdata;
endmodule

// file: test/ipm_input_ctrl_properties.sv
// Port-level properties of the input gain control block
`timescale 1ns/1ps
module ipm_input_ctrl_chk #(
  parameter int NA = 4,
  parameter int GW = 5
) (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_soft_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [9:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  input wire logic [7:0] o_pos_pin_select,
  input wire logic [NA*GW-1:0] o_active_gain,
  input wire logic [NA-1:0] o_amp_muted,
  input wire logic o_left_record_mixer_enable
);
  logic wr;
  logic mwr;
  logic [7:0] idx;
  assign idx = i_wb_adr[9:2];
  assign wr = o_wb_ack && i_wb_we;
  assign mwr = wr && idx == ipm_pkg::IDX_GAIN_1L && i_wb_dat[7];
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rstn);
  chk_ack_once: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held past one cycle");
  chk_ack_answer: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack
    |=> o_wb_ack) else $error("request not acknowledged");
  chk_reset_state: assert property ($rose(i_rstn) |-> o_amp_muted == '0
    && o_active_gain == {NA{ipm_pkg::GAIN_RESET}})
    else $error("wrong state after reset");
  chk_soft_clear: assert property (i_soft_rst |=> o_amp_muted == '0
    && o_active_gain == {NA{ipm_pkg::GAIN_RESET}} && o_pos_pin_select == 0)
    else $error("soft reset left state behind");
  chk_sel_write: assert property (wr && idx == ipm_pkg::IDX_SELECT
    |-> o_pos_pin_select == i_wb_dat[7:0]) else $error("select not taken");
  chk_mix_enable: assert property (wr && idx == ipm_pkg::IDX_POWER
    |-> o_left_record_mixer_enable == i_wb_dat[9])
    else $error("mixer enable not taken");
  chk_gain_apply: assert property (wr && idx == ipm_pkg::IDX_GAIN_1L
    && i_wb_dat[8] && !i_wb_dat[6]
    |=> o_active_gain[GW-1:0] == $past(i_wb_dat[GW-1:0]))
    else $error("strobe did not apply gain");
  chk_mute_cause: assert property ($rose(o_amp_muted[0])
    |-> mwr || $past(mwr)) else $error("mute without a mute write");
  chk_upper_zero: assert property (o_wb_ack && !i_wb_we
    |-> o_wb_dat[31:16] == 16'h0000) else $error("upper read bits set");
  chk_unmapped_zero: assert property (o_wb_ack && !i_wb_we
    && idx > ipm_pkg::IDX_STATUS |-> o_wb_dat == 32'h0)
    else $error("unmapped read not zero");
  chk_strobe_reads: assert property (o_wb_ack && !i_wb_we
    && idx[7:2] == 6'h06 |-> !o_wb_dat[8]) else $error("strobe reads 1");
  cover property (wr && idx == ipm_pkg::IDX_GAIN_1L && i_wb_dat[8]);
  cover property ($rose(o_amp_muted[0]));
  cover property (i_soft_rst);
endmodule

bind ipm_input_ctrl ipm_input_ctrl_chk #(.NA(NA), .GW(GW)) u_chk (
  .i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_soft_rst(i_soft_rst),
  .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
  .i_wb_adr(i_wb_adr), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat),
  .o_wb_ack(o_wb_ack), .o_pos_pin_select(o_pos_pin_select),
  .o_active_gain(o_active_gain), .o_amp_muted(o_amp_muted),
  .o_left_record_mixer_enable(o_left_record_mixer_enable));

// file: test/ipm_input_ctrl_tb_top.sv
// Self-checking bench for the input gain control block
`timescale 1ns/1ps
module ipm_input_ctrl_tb_top;
  logic i_clk_sys = 0, i_rstn = 0, i_soft_rst = 0;
  logic cyc = 0, stb = 0, we = 0;
  logic [3:0] sel = 4'h0, zc = 4'h0, o_amp_muted;
  logic [9:0] adr = 10'h000;
  logic [31:0] wdat = 32'h0, rd, o_wb_dat, lv, pw, sv;
  logic o_wb_ack, mid, bias, len, ren;
  logic [7:0] o_pos_pin_select, lmix, rmix;
  logic [19:0] o_active_gain;
  int bad_count = 0, checks = 0, cyc_n = 0;
  int gst[4], zcb[4], sil[4], seen0[4], act[4];

  ipm_input_ctrl DUT (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
    .i_soft_rst(i_soft_rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_sel(sel), .i_wb_adr(adr), .i_wb_dat(wdat), .o_wb_dat(o_wb_dat),
    .o_wb_ack(o_wb_ack), .i_zero_cross(zc),
    .o_pos_pin_select(o_pos_pin_select), .o_active_gain(o_active_gain),
    .o_amp_muted(o_amp_muted), .o_midrail_buffer_enable(mid),
    .o_master_bias_enable(bias), .o_left_record_mixer_enable(len),
    .o_right_record_mixer_enable(ren), .o_left_mix_levels(lmix),
    .o_right_mix_levels(rmix));

  initial forever #12.5 i_clk_sys = ~i_clk_sys;

  // Cuts a hang short; the whole run needs well under a thousand cycles
  always @(posedge i_clk_sys) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      bad_count++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Classic cycle: request held until ack is sampled, then released
  task automatic wb(input logic w, input logic [9:0] a, input logic [15:0] d);
    @(posedge i_clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h3;
    wdat <= {16'h0, d};
    // No local limit: a missing ack runs into the bench timeout
    do begin
      @(posedge i_clk_sys);
    end while (o_wb_ack !== 1'b1);
    rd = o_wb_dat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wrd(input logic [9:0] a, input logic [15:0] d);
    wb(1'b1, a, d);
    wb(1'b0, a, 16'h0);
    chk(rd, {16'h0, d});
  endtask

  task automatic cmp_out();
    logic [19:0] g;
    logic [3:0] m;
    repeat (2) @(posedge i_clk_sys);
    for (int a = 0; a < 4; a++) begin
      g[5*a +: 5] = 5'(act[a]);
      m[a] = sil[a] != 0 && seen0[a] != 0;
    end
    chk({12'h0, o_active_gain}, {12'h0, g});
    chk({28'h0, o_amp_muted}, {28'h0, m});
  endtask

  task automatic rg(input int a);
    wb(1'b0, 10'(96 + 4 * a), 16'h0);
    chk(rd, 32'(sil[a] * 128 + zcb[a] * 64 + gst[a]));
  endtask

  task automatic wg(input int a, input int g, input int z, input int s,
      input int vu);
    wb(1'b1, 10'(96 + 4 * a), 16'(vu * 256 + s * 128 + z * 64 + g));
    gst[a] = g;
    zcb[a] = z;
    sil[a] = s;
    if (s == 0)
      seen0[a] = 1;
    for (int b = 0; b < 4; b++)
      if (vu != 0 && b % 2 == a % 2 && zcb[b] == 0)
        act[b] = gst[b];
  endtask

  task automatic chk_reset();
    for (int a = 0; a < 4; a++) begin
      gst[a] = 11;
      act[a] = 11;
      zcb[a] = 0;
      sil[a] = 1;
      seen0[a] = 0;
    end
    cmp_out();
    for (int a = 0; a < 4; a++)
      rg(a);
    wb(1'b0, 10'h0a0, 16'h0);
    chk(rd, 32'h0);
    wb(1'b0, 10'h008, 16'h0);
    chk(rd, 32'h0);
    chk({24'h0, lmix}, 32'h0);
  endtask

  initial begin
    void'($urandom(6650));
    repeat (20) @(posedge i_clk_sys);
    i_rstn <= 1'b1;
    chk_reset();
    wrd(10'h008, 16'h0005);
    // Boundary codes, then random ones; strobes from either pair register
    for (int k = 0; k < 3; k++) begin
      for (int a = 0; a < 4; a++) begin
        wg(a, k == 2 ? $urandom % 32 : k * 31, 0, 1, 0);
        rg(a);
      end
      cmp_out();
      // Both registers of a pair carry its strobe
      wg(2 * (k % 2), gst[2 * (k % 2)], 0, 1, 1);
      cmp_out();
      wg(3 - 2 * (k % 2), gst[3 - 2 * (k % 2)], 0, 1, 1);
      cmp_out();
    end
    // Mute bit at 1 after reset only bites after a 0 then 1
    wrd(10'h0a0, 16'h0000);
    for (int a = 0; a < 4; a++)
      for (int s = 3; s < 6; s++) begin
        wg(a, gst[a], 0, s % 2, 0);
        cmp_out();
      end
    wg(0, 5, 1, 1, 1);
    repeat (8) @(posedge i_clk_sys);
    cmp_out();
    wb(1'b0, 10'h0c4, 16'h0);
    chk(rd, 32'h00f1);
    zc[0] <= 1'b1;
    repeat (2) @(posedge i_clk_sys);
    zc[0] <= 1'b0;
    repeat (6) @(posedge i_clk_sys);
    act[0] = 5;
    cmp_out();
    wb(1'b1, 10'h0c0, 16'h800f);
    wg(0, 9, 1, 1, 1);
    repeat (40) @(posedge i_clk_sys);
    act[0] = 9;
    cmp_out();
    for (int k = 0; k < 8; k++) begin
      wrd(10'h008, 16'h0005);
      lv = ($urandom & 32'h1b0) | k;
      pw = ($urandom & 32'h305) | 32'h5;
      sv = $urandom % 256;
      wrd(10'h0a4, lv[15:0]);
      wrd(10'h0ac, 16'(k * 64 + 7 - k));
      wrd(10'h054, 16'((k % 2) * 128));
      wrd(10'h008, pw[15:0]);
      wrd(10'h0a0, sv[15:0]);
      repeat (2) @(posedge i_clk_sys);
      chk({24'h0, o_pos_pin_select}, sv);
      chk({24'h0, lmix}, {24'h0, lv[5], lv[8], k != 0, k != 7, k != 0,
        pw[9], lv[4], lv[7]});
      chk({28'h0, len, ren, mid, bias}, {28'h0, pw[9], pw[8], pw[2],
        pw[0]});
      chk({24'h0, rmix}, {29'h0, pw[8], 2'h0});
    end
    wb(1'b1, 10'h3fc, 16'hffff);
    wb(1'b0, 10'h3fc, 16'h0);
    chk(rd, 32'h0);
    i_soft_rst <= 1'b1;
    @(posedge i_clk_sys);
    i_soft_rst <= 1'b0;
    chk_reset();
    test_done();
  end
endmodule
